// file: src/iscs_common_cmds.sv
// Common status command interpreter of the meter
`timescale 1ns/1ps
`default_nettype none
module iscs_common_cmds
    import iscs_pkg::*;
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // Parsed command
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire iscs_pkg::iscs_cmd_pkt_type cmd,
    // Reply stream
    output iscs_pkg::iscs_reply_type      reply,
    output logic                          reply_valid,
    input  wire logic                     reply_ready,
    // Instrument status
    input  wire logic [7:0]               event_set,
    input  wire logic [7:0]               status_in,
    input  wire logic                     queue_pending,
    // Actions and status
    output logic                          trigger_pulse,
    output logic                          reset_pulse,
    output logic                          queue_flush,
    output logic                          service_request,
    output logic [7:0]                    summary_status_byte,
    output logic [7:0]                    standard_event_flags,
    output logic [7:0]                    event_enable_mask,
    output logic [7:0]                    service_request_mask
);
    function automatic logic arg_ok(input logic signed [15:0] a);
        return (int'(a) >= ARG_MIN) && (int'(a) <= ARG_MAX);
    endfunction

    function automatic logic is_num_query(input iscs_cmd_type c);
        return (c == cmd_evt_mask_query) || (c == cmd_evt_query)
            || (c == cmd_srq_mask_query) || (c == cmd_status_query)
            || (c == cmd_opc_query);
    endfunction

    iscs_state_type   state;
    logic fire;
    assign fire      = cmd_valid && cmd_ready;
    assign cmd_ready = (state == st_idle);

    // Status register group
    logic [7:0] next_evt_mask;
    logic [7:0] next_evt;
    logic [7:0] next_srq_mask;
    logic [7:0] next_status;
    logic       next_trig;
    logic       next_rst;
    logic       next_flush;
    logic       exec_err;
    logic       opc_evt;

    always_comb begin
        next_evt_mask = event_enable_mask;
        next_evt      = standard_event_flags;
        next_srq_mask = service_request_mask;
        exec_err      = 1'b0;
        opc_evt       = 1'b0;
        next_trig     = 1'b0;
        next_rst      = 1'b0;
        next_flush    = 1'b0;
        if (fire) begin
            case (cmd.code)
                cmd_clear_status: begin
                    next_evt   = REG_RESET;
                    next_flush = cmd.first;
                end
                cmd_evt_mask_set: begin
                    if (arg_ok(cmd.arg)) begin
                        next_evt_mask = cmd.arg[7:0];
                    end else begin
                        exec_err = 1'b1;
                    end
                end
                cmd_evt_query: begin
                    next_evt = REG_RESET;
                end
                cmd_opc_set: begin
                    opc_evt = 1'b1;
                end
                cmd_reset: begin
                    next_rst = 1'b1;
                end
                cmd_srq_mask_set: begin
                    if (arg_ok(cmd.arg)) begin
                        next_srq_mask = cmd.arg[7:0];
                        next_srq_mask[SRQ_UNUSED_POS] = 1'b0;
                    end else begin
                        exec_err = 1'b1;
                    end
                end
                cmd_trigger: begin
                    next_trig = 1'b1;
                end
                cmd_wait: begin
                    next_trig = 1'b0;
                end
                default: begin
                    next_trig = 1'b0;
                end
            endcase
        end
        next_evt = next_evt | event_set;
        if (exec_err) begin
            next_evt[EVT_EXEC_POS] = 1'b1;
        end
        if (opc_evt) begin
            next_evt[EVT_OPC_POS] = 1'b1;
        end
        next_status = status_in;
        next_status[SUM_MAV_POS] = queue_pending || reply_valid || (state != st_idle);
        next_status[SUM_ESB_POS] = |(standard_event_flags & event_enable_mask);
        next_status[SUM_MSS_POS] = 1'b0;
        next_status[SUM_MSS_POS] = |(next_status & service_request_mask);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            event_enable_mask    <= REG_RESET;
            standard_event_flags <= REG_RESET;
            service_request_mask <= REG_RESET;
            summary_status_byte  <= REG_RESET;
            service_request      <= 1'b0;
            trigger_pulse        <= 1'b0;
            reset_pulse          <= 1'b0;
            queue_flush          <= 1'b0;
        end else begin
            event_enable_mask    <= next_evt_mask;
            standard_event_flags <= next_evt;
            service_request_mask <= next_srq_mask;
            summary_status_byte  <= next_status;
            service_request      <= next_status[SUM_MSS_POS];
            trigger_pulse        <= next_trig;
            reset_pulse          <= next_rst;
            queue_flush          <= next_flush;
        end
    end

    // Reply sequencer group
    iscs_state_type   next_state;
    iscs_reply_type   next_reply;
    logic             next_rvalid;
    logic [2:0][3:0]  dig;
    logic [2:0][3:0]  next_dig;
    logic [1:0]       cnt;
    logic [1:0]       next_cnt;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] next_idx;
    logic             rom_ok;
    logic             next_rom_ok;
    logic             dec_start;
    logic [7:0]       dec_value;
    logic             dec_done;
    logic [7:0]       rom_q;
    iscs_digits_type  dec_digits;

    always_comb begin
        dec_start = fire && is_num_query(cmd.code);
        case (cmd.code)
            cmd_evt_mask_query: dec_value = event_enable_mask;
            cmd_evt_query:      dec_value = standard_event_flags;
            cmd_srq_mask_query: dec_value = service_request_mask;
            cmd_status_query:   dec_value = summary_status_byte;
            cmd_opc_query:      dec_value = OPC_VALUE;
            default:            dec_value = REG_RESET;
        endcase
    end

    always_comb begin
        next_state  = state;
        next_reply  = reply;
        next_rvalid = reply_valid;
        next_dig    = dig;
        next_cnt    = cnt;
        next_idx    = idx;
        next_rom_ok = 1'b1;
        case (state)
            st_idle: begin
                if (dec_start) begin
                    next_state = st_conv;
                end else if (fire && (cmd.code == cmd_idn_query)) begin
                    next_state  = st_ident;
                    next_idx    = '0;
                    next_rom_ok = 1'b0;
                end
            end
            st_conv: begin
                if (dec_done) begin
                    next_dig   = dec_digits.dig;
                    next_cnt   = dec_digits.count;
                    next_state = st_digits;
                end
            end
            st_digits: begin
                if (!reply_valid || reply_ready) begin
                    if (cnt != 2'd0) begin
                        next_reply.char = ASCII_ZERO + {4'h0, dig[cnt - 2'd1]};
                        next_reply.last = (cnt == 2'd1);
                        next_rvalid     = 1'b1;
                        next_cnt        = cnt - 2'd1;
                    end else begin
                        next_rvalid = 1'b0;
                        next_state  = st_idle;
                    end
                end
            end
            st_ident: begin
                if (!reply_valid || reply_ready) begin
                    next_rvalid = 1'b0;
                    if (idx == IDX_W'(IDN_LEN)) begin
                        next_state = st_idle;
                    end else if (rom_ok) begin
                        next_reply.char = rom_q;
                        next_reply.last = (idx == IDX_W'(IDN_LEN - 1));
                        next_rvalid     = 1'b1;
                        next_idx        = idx + 1'b1;
                        next_rom_ok     = 1'b0;
                    end
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state       <= st_idle;
            reply       <= '0;
            reply_valid <= 1'b0;
            dig         <= '0;
            cnt         <= 2'd0;
            idx         <= '0;
            rom_ok      <= 1'b0;
        end else begin
            state       <= next_state;
            reply       <= next_reply;
            reply_valid <= next_rvalid;
            dig         <= next_dig;
            cnt         <= next_cnt;
            idx         <= next_idx;
            rom_ok      <= next_rom_ok;
        end
    end

    iscs_dec_fmt u_dec (
        .clock  (clock),
        .rst_n  (rst_n),
        .start  (dec_start),
        .value  (dec_value),
        .digits (dec_digits),
        .done   (dec_done)
    );

    iscs_idn_rom u_rom (
        .clock (clock),
        .rst_n (rst_n),
        .addr  (idx),
        .q     (rom_q)
    );

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    cls_clear_a: assert property (
        fire && cmd.code == cmd_clear_status && event_set == 8'h00 |=>
        standard_event_flags == 8'h00 && queue_flush == $past(cmd.first))
        else $error("clear status did not clear events");

    evt_mask_load_a: assert property (
        fire && cmd.code == cmd_evt_mask_set && arg_ok(cmd.arg) |=>
        event_enable_mask == $past(cmd.arg[7:0]))
        else $error("event enable not loaded");

    evt_mask_range_a: assert property (
        fire && cmd.code == cmd_evt_mask_set && !arg_ok(cmd.arg) |=>
        event_enable_mask == $past(event_enable_mask) && standard_event_flags[EVT_EXEC_POS])
        else $error("bad event enable argument not flagged");

    evt_clear_a: assert property (
        fire && cmd.code == cmd_evt_query && event_set == 8'h00 |=>
        standard_event_flags == 8'h00)
        else $error("event status not cleared by query");

    opc_set_a: assert property (
        fire && cmd.code == cmd_opc_set |=> standard_event_flags[EVT_OPC_POS])
        else $error("operation complete bit not set");

    opc_reply_a: assert property (
        fire && cmd.code == cmd_opc_query |-> ##[2:4]
        reply_valid && reply.char == ASCII_ONE && reply.last)
        else $error("operation complete reply missing");

    rst_keep_a: assert property (
        fire && cmd.code == cmd_reset && event_set == 8'h00 |=> reset_pulse
        && standard_event_flags == $past(standard_event_flags)
        && event_enable_mask == $past(event_enable_mask))
        else $error("reset disturbed status");

    srq_bit6_a: assert property (
        service_request_mask[SRQ_UNUSED_POS] == 1'b0)
        else $error("service enable bit six set");

    mss_set_a: assert property (
        |(standard_event_flags & event_enable_mask) && service_request_mask[SUM_ESB_POS]
        |=> summary_status_byte[SUM_MSS_POS] && service_request)
        else $error("summary bit not raised");

    trg_pulse_a: assert property (
        fire && cmd.code == cmd_trigger |=> trigger_pulse ##1 !trigger_pulse)
        else $error("trigger pulse wrong");

    wai_none_a: assert property (
        fire && cmd.code == cmd_wait && event_set == 8'h00 |=> !trigger_pulse
        && !reset_pulse && standard_event_flags == $past(standard_event_flags))
        else $error("wait command had an effect");

    idn_first_a: assert property (
        fire && cmd.code == cmd_idn_query |-> ##[2:4]
        reply_valid && reply.char == IDN_TEXT[8*IDN_LEN-1 -: 8])
        else $error("identification reply missing");

    idn_cov: cover property (reply_valid && reply_ready && reply.last && state == st_ident);
    num_cov: cover property (reply_valid && reply_ready && reply.last && state == st_digits);
    err_cov: cover property (exec_err);
    srq_cov: cover property (service_request);
endmodule
`default_nettype wire

// file: src/iscs_dec_fmt.sv
// Byte to decimal digit converter with registered result
`timescale 1ns/1ps
`default_nettype none
module iscs_dec_fmt
    import iscs_pkg::*;
(
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    // Request
    input  wire logic            start,
    input  wire logic [7:0]      value,
    // Result
    output iscs_pkg::iscs_digits_type digits,
    output logic                 done
);
    iscs_digits_type next_digits;

    always_comb begin
        next_digits.dig[2] = 4'(value / 8'd100);
        next_digits.dig[1] = 4'((value / 8'd10) % 8'd10);
        next_digits.dig[0] = 4'(value % 8'd10);
        if (value >= 8'd100) begin
            next_digits.count = 2'd3;
        end else if (value >= 8'd10) begin
            next_digits.count = 2'd2;
        end else begin
            next_digits.count = 2'd1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            digits <= '0;
            done   <= 1'b0;
        end else begin
            if (start) begin
                digits <= next_digits;
            end
            done <= start;
        end
    end
endmodule
`default_nettype wire

// file: src/iscs_idn_rom.sv
// Identification text store with registered read data
`timescale 1ns/1ps
`default_nettype none
module iscs_idn_rom
    import iscs_pkg::*;
#(
    parameter int                    LEN  = IDN_LEN,
    parameter logic [8*LEN-1:0]      TEXT = IDN_TEXT
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Read port
    input  wire logic [IDX_W-1:0] addr,
    output logic [7:0]            q
);
    logic [7:0] next_q;

    always_comb begin
        next_q = 8'h00;
        if (int'(addr) < LEN) begin
            next_q = TEXT[8*(LEN-1-int'(addr)) +: 8];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= 8'h00;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// file: src/iscs_pkg.sv
// Constants and types for the common status command interpreter
package iscs_pkg;

    // Argument range of the enable set commands
    localparam int ARG_MIN = 0;
    localparam int ARG_MAX = 255;

    // Event status bit positions
    localparam int EVT_OPC_POS  = 0;
    localparam int EVT_EXEC_POS = 4;

    // Status byte bit positions
    localparam int SUM_MAV_POS    = 4;
    localparam int SUM_ESB_POS    = 5;
    localparam int SUM_MSS_POS    = 6;
    localparam int SRQ_UNUSED_POS = 6;

    // Reset values and characters
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_ONE  = 8'h31;
    localparam logic [7:0] OPC_VALUE  = 8'h01;

    // Identification reply, value arbitrary
    localparam int IDN_LEN = 26;
    localparam int IDX_W   = 5;
    localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "ACME,DMM0,1234567,1.0,D1.0";

    typedef enum logic [3:0] {
        cmd_clear_status   = 4'h0,
        cmd_evt_mask_set   = 4'h1,
        cmd_evt_mask_query = 4'h2,
        cmd_evt_query      = 4'h3,
        cmd_idn_query      = 4'h4,
        cmd_opc_set        = 4'h5,
        cmd_opc_query      = 4'h6,
        cmd_reset          = 4'h7,
        cmd_srq_mask_set   = 4'h8,
        cmd_srq_mask_query = 4'h9,
        cmd_status_query   = 4'ha,
        cmd_trigger        = 4'hb,
        cmd_wait           = 4'hc
    } iscs_cmd_type;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_conv   = 2'b01,
        st_digits = 2'b11,
        st_ident  = 2'b10
    } iscs_state_type;

    typedef struct packed {
        iscs_cmd_type       code;
        logic signed [15:0] arg;
        logic               first;
    } iscs_cmd_pkt_type;

    typedef struct packed {
        logic [7:0] char;
        logic       last;
    } iscs_reply_type;

    typedef struct packed {
        logic [2:0][3:0] dig;
        logic [1:0]      count;
    } iscs_digits_type;

endpackage

// file: test/iscs_reply_sink.sv
// Remote controller model that takes reply characters
`timescale 1ns/1ps
`default_nettype none
module iscs_reply_sink
    import iscs_pkg::*;
(
    // Clock
    input  wire logic                    clock,
    // Reply stream
    input  wire iscs_pkg::iscs_reply_type reply,
    input  wire logic                    reply_valid,
    output logic                         reply_ready,
    // Pacing
    input  wire logic                    slow
);
    import iscs_pkg::*;

    string text;
    logic  done;

    initial begin
        text = "";
        done = 1'b0;
        reply_ready = 1'b0;
    end

    // Collect characters, stall every other cycle when slow
    always @(posedge clock) begin
        if (reply_valid && reply_ready) begin
            text = $sformatf("%s%c", text, reply.char);
            if (reply.last) begin
                done = 1'b1;
            end
        end
        #1;
        reply_ready = slow ? ~reply_ready : 1'b1;
    end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the common status command interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); end end
module testbench;
    import iscs_pkg::*;

    typedef struct {iscs_cmd_type code; int arg; string exp;} iscs_row_type;

    logic                     clock = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     cmd_valid = 1'b0;
    logic                     cmd_ready;
    iscs_cmd_pkt_type         cmd = '0;
    iscs_reply_type           reply;
    logic                     reply_valid;
    logic                     reply_ready;
    logic [7:0]               event_set = 8'h00;
    logic [7:0]               status_in = 8'h00;
    logic                     queue_pending = 1'b0;
    logic                     trigger_pulse, reset_pulse, queue_flush, service_request;
    logic [7:0]               summary_status_byte, standard_event_flags;
    logic [7:0]               event_enable_mask, service_request_mask;
    logic                     slow = 1'b0;
    int                       n_errors = 0;
    int                       cmp_count = 0;
    string                    idn;
    int                       commas;
    iscs_row_type             rows [12] = '{
        '{cmd_evt_mask_set, 16, ""}, '{cmd_evt_mask_query, 0, "16"},
        '{cmd_srq_mask_set, 255, ""}, '{cmd_srq_mask_query, 0, "191"},
        '{cmd_evt_mask_set, 255, ""}, '{cmd_evt_mask_query, 0, "255"},
        '{cmd_evt_mask_set, 0, ""}, '{cmd_evt_mask_query, 0, "0"},
        '{cmd_opc_query, 0, "1"}, '{cmd_wait, 0, ""},
        '{cmd_srq_mask_set, 0, ""}, '{cmd_srq_mask_query, 0, "0"}};

    always #12.5 clock = ~clock;

    iscs_common_cmds i_dut (
        .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .reply(reply), .reply_valid(reply_valid), .reply_ready(reply_ready),
        .event_set(event_set), .status_in(status_in), .queue_pending(queue_pending),
        .trigger_pulse(trigger_pulse), .reset_pulse(reset_pulse),
        .queue_flush(queue_flush), .service_request(service_request),
        .summary_status_byte(summary_status_byte),
        .standard_event_flags(standard_event_flags),
        .event_enable_mask(event_enable_mask),
        .service_request_mask(service_request_mask)
    );

    iscs_reply_sink i_sink (
        .clock(clock), .reply(reply), .reply_valid(reply_valid),
        .reply_ready(reply_ready), .slow(slow)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic send(input iscs_cmd_type c, input int a, input logic f);
        int n;
        n = 0;
        // Idle edge between requests
        tick(1);
        cmd = '{code: c, arg: a[15:0], first: f};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        `CHK(cmd_ready, 1'b1, "command not taken")
        tick(1);
        cmd_valid = 1'b0;
    endtask

    task automatic query(input iscs_cmd_type c, input string exp);
        int n;
        n = 0;
        i_sink.text = "";
        i_sink.done = 1'b0;
        send(c, 0, 1'b0);
        while (i_sink.done !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        `CHK(i_sink.text == exp, 1'b1, "reply text")
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clock);
        #1;
        rst_n = 1'b1;
        `CHK({event_enable_mask, service_request_mask, standard_event_flags}, 24'h0, "reset")
        `CHK(cmd_ready, 1'b1, "ready after reset")
        $display("test reset done");
        // Ordinary cases
        foreach (rows[i]) begin
            if (rows[i].exp == "") begin
                send(rows[i].code, rows[i].arg, 1'b0);
            end else begin
                query(rows[i].code, rows[i].exp);
            end
        end
        $display("test table done");
        // Out of range and summary bit
        send(cmd_evt_mask_set, 16, 1'b0);
        send(cmd_srq_mask_set, 32, 1'b0);
        send(cmd_evt_mask_set, 300, 1'b0);
        tick(1);
        `CHK(event_enable_mask, 8'h10, "event mask kept")
        `CHK(standard_event_flags[EVT_EXEC_POS], 1'b1, "exec error bit")
        queue_pending = 1'b1;
        tick(4);
        `CHK(service_request, 1'b1, "summary bit")
        query(cmd_status_query, "112");
        queue_pending = 1'b0;
        send(cmd_srq_mask_set, -1, 1'b0);
        tick(1);
        `CHK(service_request_mask, 8'h20, "service mask kept")
        send(cmd_srq_mask_set, 65, 1'b0);
        tick(1);
        `CHK(service_request_mask, 8'h01, "bit six dropped")
        $display("test summary done");
        // Event status readout
        send(cmd_opc_set, 0, 1'b0);
        `CHK(standard_event_flags[EVT_OPC_POS], 1'b1, "opc bit")
        event_set = 8'h80;
        tick(1);
        event_set = 8'h00;
        tick(2);
        query(cmd_evt_query, "145");
        `CHK(standard_event_flags, 8'h00, "cleared on read")
        $display("test event status done");
        // Reset keeps status
        send(cmd_opc_set, 0, 1'b0);
        send(cmd_reset, 0, 1'b0);
        `CHK(reset_pulse, 1'b1, "reset pulse")
        tick(1);
        `CHK({reset_pulse, standard_event_flags, event_enable_mask}, 17'h00110, "kept")
        // Clear status
        send(cmd_clear_status, 0, 1'b0);
        `CHK({queue_flush, standard_event_flags}, 9'h000, "clear not first")
        send(cmd_clear_status, 0, 1'b1);
        `CHK(queue_flush, 1'b1, "flush when first")
        $display("test reset and clear done");
        // Trigger and wait
        send(cmd_trigger, 0, 1'b0);
        `CHK(trigger_pulse, 1'b1, "trigger pulse")
        tick(1);
        `CHK(trigger_pulse, 1'b0, "single pulse")
        send(cmd_wait, 0, 1'b0);
        `CHK({trigger_pulse, reset_pulse, queue_flush}, 3'b000, "no action")
        tick(1);
        `CHK(standard_event_flags, 8'h00, "no error")
        $display("test trigger done");
        // Reset in mid-run clears the registers
        send(cmd_evt_mask_set, 8, 1'b0);
        rst_n = 1'b0;
        tick(2);
        `CHK({event_enable_mask, cmd_ready, reply_valid}, 10'h002, "mid-run reset")
        rst_n = 1'b1;
        $display("test mid-run reset done");
        // Identification with a stalling controller
        slow = 1'b1;
        idn = $sformatf("%s", IDN_TEXT);
        query(cmd_idn_query, idn);
        commas = 0;
        for (int i = 0; i < idn.len(); i++) begin
            if (i_sink.text.len() > i && i_sink.text[i] == ",") begin
                commas++;
            end
        end
        `CHK(commas, 4, "field count")
        slow = 1'b0;
        $display("test identification done");
        complete_run();
    end
endmodule
`default_nettype wire
